// File: lcdrst_defines.svh
/*
 * Constants of the LCD driver reset and initial-state block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes it is included by its bare name from the shift and top modules.
 */
`ifndef LCDRST_DEFINES_SVH
`define LCDRST_DEFINES_SVH

// ****************************************************************
// APB register offsets (byte addresses)
// ****************************************************************
`define LCDRST_OFS_CMD 12'h000
`define LCDRST_OFS_STATUS 12'h004
`define LCDRST_OFS_CTRL 12'h008
`define LCDRST_OFS_POWER 12'h00c
`define LCDRST_OFS_ADDR 12'h010
`define LCDRST_OFS_ANALOG 12'h014
`define LCDRST_OFS_SERIAL 12'h018

// ****************************************************************
// Command register values
// ****************************************************************
`define LCDRST_CMD_SWRESET 8'he2
`define LCDRST_CMD_POWERSAVE 8'ha9

// ****************************************************************
// Status byte bit positions
// ****************************************************************
`define LCDRST_ST_BUSY 7
`define LCDRST_ST_MAP 6
`define LCDRST_ST_ONOFF 5
`define LCDRST_ST_RESET 4

// ****************************************************************
// Reset values
// ****************************************************************
`define LCDRST_RST_POWER 3'h0
`define LCDRST_RST_BIAS 1'h0
`define LCDRST_RST_INDIC 2'h0
`define LCDRST_RST_START 6'h00
`define LCDRST_RST_COLUMN 8'h00
`define LCDRST_RST_PAGE 4'h0
`define LCDRST_RST_DIVIDER 3'h0
`define LCDRST_RST_CONTRAST 6'h20
`define LCDRST_RST_NLINE 4'h0
`define LCDRST_RST_STATUS 8'hf0

// ****************************************************************
// Timing
// ****************************************************************
`define LCDRST_CLK_NS 10
`define LCDRST_INIT_NS 80
`define LCDRST_INIT_CYC ((`LCDRST_INIT_NS + `LCDRST_CLK_NS - 1) / `LCDRST_CLK_NS)
`define LCDRST_INIT_W 4

`endif

// File: lcdrst_pkg.sv
/*
 * Types of the LCD driver reset and initial-state block.
 * Assumes lcdrst_defines.svh is available on the include path.
 */
package lcdrst_pkg;

    // ****************************************************************
    // Reset sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        LCDRST_HW   = 3'b001,
        LCDRST_INIT = 3'b010,
        LCDRST_RUN  = 3'b100
    } lcdrst_state_e;

    // ****************************************************************
    // Settings restored only by the hardware reset
    // ****************************************************************
    typedef struct packed {
        logic display_on;
        logic inverse;
        logic seg_reverse;
        logic [2:0] power_ctrl;
        logic bias_1_7;
        logic nline_on;
        logic power_save;
        logic all_on;
        logic osc_on;
    } lcdrst_core_s;

    // ****************************************************************
    // Settings restored by either reset source
    // ****************************************************************
    typedef struct packed {
        logic [1:0] indicator;
        logic rmw;
        logic [5:0] start_line;
        logic [7:0] column;
        logic [3:0] page;
        logic com_reverse;
        logic [2:0] divider;
        logic contrast_mode;
        logic [5:0] contrast;
        logic [3:0] nline_count;
        logic test_mode;
    } lcdrst_soft_s;

endpackage

// File: lcdrst_shift.sv
/*
 * Serial interface shift register of the LCD driver. Eight bits in,
 * most significant first, one byte out with a valid pulse.
 * Assumes serial strobes are synchronous to i_clk.
 */
`timescale 1ns/1ps
`include "lcdrst_defines.svh"

module lcdrst_shift (
    // Clock and clear
    input wire logic i_clk,
    input wire logic i_clear,
    // Serial input
    input wire logic i_bit_valid,
    input wire logic i_bit,
    // Byte output
    output logic [7:0] o_byte,
    output logic o_byte_valid,
    output logic [2:0] o_count
);

    logic [6:0] shift;

    // ****************************************************************
    // Shifting; a clear drops any partial byte
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        o_byte_valid <= 1'b0;
        if (i_clear) begin
            shift <= 7'h00;
            o_count <= 3'h0;
            o_byte <= 8'h00;
        end else if (i_bit_valid) begin
            o_count <= o_count + 3'h1;
            if (o_count == 3'h7) begin
                o_byte <= {shift, i_bit};
                o_byte_valid <= 1'b1;
            end else begin
                shift <= {shift[5:0], i_bit};
            end
        end
    end

endmodule

// File: lcdrst_top.sv
/*
 * Reset and initial-state logic of a dot-matrix LCD driver, with an
 * APB slave for the host's settings and commands.
 * Assumes APB signals synchronous to i_clk, and that the host pulses
 * hardware_reset_n after power-up.
 */
// Added by the designer: register access over APB and the register offsets.
// Behaviour
// - Reset low: display off, normal, normal mapping
// - Hardware reset: power bits zero, save off, oscillator stopped
// - Hardware reset discards partial serial bits
// - Hardware reset selects 1/9 bias
// - Hardware reset cancels multi-line inversion
// - Hardware reset disables all-pixels-on
// - Either reset clears static indicator bits
// - Either reset leaves read-modify-write mode
// - Either reset sets start line first
// - Either reset loads column counter zero
// - Either reset loads page zero
// - Either reset sets normal common scan
// - Either reset clears divider ratio register
// - Either reset: contrast mode off, midpoint
// - Either reset clears line count, test mode
// - Software reset restores only shared items
// - Reset low discharges drive and boost nodes
// - Status bit four shows resetting
// - Status bit seven shows busy
`timescale 1ns/1ps
`include "lcdrst_defines.svh"

module lcdrst_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_hardware_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Serial command input
    input wire logic i_ser_valid,
    input wire logic i_ser_bit,
    // Display and power controls
    output lcdrst_pkg::lcdrst_core_s o_core,
    output lcdrst_pkg::lcdrst_soft_s o_soft,
    output logic o_discharge_drive,
    output logic o_discharge_boost,
    output logic [7:0] o_status
);

    lcdrst_pkg::lcdrst_state_e state;
    lcdrst_pkg::lcdrst_state_e next_state;
    logic [`LCDRST_INIT_W-1:0] init_cnt;
    logic hw_rst;
    logic sw_rst;
    logic apb_wr;
    logic [7:0] ser_byte;
    logic ser_byte_valid;
    logic [2:0] ser_count;
    logic [7:0] next_status;

    // Hardware pin acts as reset together with the system reset
    assign hw_rst = !i_nrst || !i_hardware_reset_n;
    assign apb_wr = i_psel && i_penable && i_pwrite;

    function automatic logic is_cmd(input logic [7:0] b,
                                    input logic [7:0] code);
        is_cmd = (b == code);
    endfunction

    // Register write strobe for one offset
    function automatic logic wr_hit(input logic wr,
                                    input logic [11:0] a,
                                    input logic [11:0] ofs);
        wr_hit = wr && (a == ofs);
    endfunction

    // Offsets that answer without an error
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `LCDRST_OFS_CMD) || (a == `LCDRST_OFS_STATUS)
            || (a == `LCDRST_OFS_CTRL) || (a == `LCDRST_OFS_POWER)
            || (a == `LCDRST_OFS_ADDR) || (a == `LCDRST_OFS_ANALOG)
            || (a == `LCDRST_OFS_SERIAL);
    endfunction

    // Software reset from APB command write or serial byte
    assign sw_rst = (wr_hit(apb_wr, i_paddr, `LCDRST_OFS_CMD)
                     && is_cmd(i_pwdata[7:0], `LCDRST_CMD_SWRESET))
                 || (ser_byte_valid
                     && is_cmd(ser_byte, `LCDRST_CMD_SWRESET));

    // ****************************************************************
    // Serial shift register
    // ****************************************************************
    lcdrst_shift i_lcdrst_shift (
        .i_clk(i_clk),
        .i_clear(hw_rst),
        .i_bit_valid(i_ser_valid),
        .i_bit(i_ser_bit),
        .o_byte(ser_byte),
        .o_byte_valid(ser_byte_valid),
        .o_count(ser_count)
    );

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            lcdrst_pkg::LCDRST_HW: begin
                next_state = lcdrst_pkg::LCDRST_INIT;
            end
            lcdrst_pkg::LCDRST_INIT: begin
                if (init_cnt == `LCDRST_INIT_W'(`LCDRST_INIT_CYC - 1)) begin
                    next_state = lcdrst_pkg::LCDRST_RUN;
                end
            end
            lcdrst_pkg::LCDRST_RUN: begin
                // Only from here: a soft reset inside the init window is
                // not restarted, hosts wait for busy to clear first
                if (sw_rst) begin
                    next_state = lcdrst_pkg::LCDRST_INIT;
                end
            end
            default: begin
                next_state = lcdrst_pkg::LCDRST_HW;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (hw_rst) begin
            state <= lcdrst_pkg::LCDRST_HW;
            init_cnt <= '0;
        end else begin
            state <= next_state;
            if (state == lcdrst_pkg::LCDRST_INIT) begin
                init_cnt <= init_cnt + `LCDRST_INIT_W'(1);
            end else begin
                init_cnt <= '0;
            end
        end
    end

    // ****************************************************************
    // Settings kept across a software reset
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (hw_rst) begin
            o_core.display_on <= 1'b0;
            o_core.inverse <= 1'b0;
            o_core.seg_reverse <= 1'b0;
            o_core.power_ctrl <= `LCDRST_RST_POWER;
            o_core.power_save <= 1'b0;
            o_core.osc_on <= 1'b0;
            o_core.bias_1_7 <= `LCDRST_RST_BIAS;
            o_core.nline_on <= 1'b0;
            o_core.all_on <= 1'b0;
        end else if (wr_hit(apb_wr, i_paddr, `LCDRST_OFS_CTRL)) begin
            // Software reset leaves this group untouched
            o_core.display_on <= i_pwdata[0];
            o_core.inverse <= i_pwdata[1];
            o_core.seg_reverse <= i_pwdata[2];
            o_core.bias_1_7 <= i_pwdata[3];
            o_core.nline_on <= i_pwdata[4];
            o_core.all_on <= i_pwdata[5];
            o_core.osc_on <= i_pwdata[6];
        end else if (wr_hit(apb_wr, i_paddr, `LCDRST_OFS_POWER)) begin
            o_core.power_ctrl <= i_pwdata[2:0];
            o_core.power_save <= i_pwdata[3];
        end else if (wr_hit(apb_wr, i_paddr, `LCDRST_OFS_CMD)
                     && is_cmd(i_pwdata[7:0], `LCDRST_CMD_POWERSAVE)) begin
            // Host must do this before cutting the supply
            o_core.power_save <= 1'b1;
        end
    end

    // ****************************************************************
    // Settings restored by either reset source
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (hw_rst || sw_rst) begin
            o_soft.indicator <= `LCDRST_RST_INDIC;
            o_soft.rmw <= 1'b0;
            o_soft.start_line <= `LCDRST_RST_START;
            o_soft.column <= `LCDRST_RST_COLUMN;
            o_soft.page <= `LCDRST_RST_PAGE;
            o_soft.com_reverse <= 1'b0;
            o_soft.divider <= `LCDRST_RST_DIVIDER;
            o_soft.contrast_mode <= 1'b0;
            o_soft.contrast <= `LCDRST_RST_CONTRAST;
            o_soft.nline_count <= `LCDRST_RST_NLINE;
            o_soft.test_mode <= 1'b0;
        end else if (wr_hit(apb_wr, i_paddr, `LCDRST_OFS_ADDR)) begin
            o_soft.column <= i_pwdata[7:0];
            o_soft.page <= i_pwdata[11:8];
            o_soft.start_line <= i_pwdata[17:12];
            o_soft.rmw <= i_pwdata[18];
            o_soft.com_reverse <= i_pwdata[19];
            o_soft.indicator <= i_pwdata[21:20];
        end else if (wr_hit(apb_wr, i_paddr, `LCDRST_OFS_ANALOG)) begin
            o_soft.divider <= i_pwdata[2:0];
            o_soft.contrast <= i_pwdata[8:3];
            o_soft.contrast_mode <= i_pwdata[9];
            o_soft.nline_count <= i_pwdata[13:10];
            o_soft.test_mode <= i_pwdata[14];
        end
    end

    // ****************************************************************
    // Discharge of generated voltages
    // ****************************************************************
    // Registered, so the discharge lags the pin by one edge
    always_ff @(posedge i_clk) begin
        o_discharge_drive <= hw_rst;
    end

    // Boost node has its own switch, so its own flip-flop
    always_ff @(posedge i_clk) begin
        o_discharge_boost <= hw_rst;
    end

    // ****************************************************************
    // Status byte
    // ****************************************************************
    // Reads decode the next state, so a status read right after a
    // command already reports busy
    always_comb begin
        next_status = 8'h00;
        next_status[`LCDRST_ST_BUSY] =
            (next_state != lcdrst_pkg::LCDRST_RUN) || hw_rst;
        next_status[`LCDRST_ST_MAP] = !o_core.seg_reverse;
        next_status[`LCDRST_ST_ONOFF] = !o_core.display_on;
        next_status[`LCDRST_ST_RESET] =
            (next_state != lcdrst_pkg::LCDRST_RUN) || hw_rst;
    end

    always_ff @(posedge i_clk) begin
        if (hw_rst) begin
            o_status <= `LCDRST_RST_STATUS;
        end else begin
            o_status <= next_status;
        end
    end

    // ****************************************************************
    // APB slave: zero wait states, error on unmapped address
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
        end
    end

    // Writes to an unmapped offset are dropped by the decode above
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= i_psel && !i_penable && !is_mapped(i_paddr);
        end
    end

    // Read data stands in the access cycle only, zero otherwise
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0;
        end else if (i_psel && !i_penable) begin
            unique case (i_paddr)
                `LCDRST_OFS_CMD: o_prdata <= 32'h0;
                `LCDRST_OFS_STATUS: o_prdata <= {24'h0, next_status};
                `LCDRST_OFS_CTRL: o_prdata <= {25'h0,
                    o_core.osc_on, o_core.all_on, o_core.nline_on,
                    o_core.bias_1_7, o_core.seg_reverse,
                    o_core.inverse, o_core.display_on};
                `LCDRST_OFS_POWER: o_prdata <= {28'h0,
                    o_core.power_save, o_core.power_ctrl};
                `LCDRST_OFS_ADDR: o_prdata <= {10'h0,
                    o_soft.indicator, o_soft.com_reverse, o_soft.rmw,
                    o_soft.start_line, o_soft.page, o_soft.column};
                `LCDRST_OFS_ANALOG: o_prdata <= {17'h0,
                    o_soft.test_mode, o_soft.nline_count,
                    o_soft.contrast_mode, o_soft.contrast,
                    o_soft.divider};
                `LCDRST_OFS_SERIAL: o_prdata <= {21'h0, ser_count,
                    ser_byte};
                default: o_prdata <= 32'h0;
            endcase
        end else begin
            o_prdata <= 32'h0;
        end
    end

endmodule

// File: lcdrst_top_properties.sv
/*
 * Port checker of the LCD driver reset block.
 * Assumes it is bound to lcdrst_top, one clock, i_nrst low resets.
 */
`timescale 1ns/1ps
module lcdrst_top_properties (
    // Clock and resets
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_hardware_reset_n,
    // APB and serial
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_ser_valid,
    // Outputs
    input wire lcdrst_pkg::lcdrst_core_s o_core,
    input wire lcdrst_pkg::lcdrst_soft_s o_soft,
    input wire logic o_discharge_drive,
    input wire logic o_discharge_boost,
    input wire logic [7:0] o_status
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    localparam lcdrst_pkg::lcdrst_soft_s SOFT_DEF =
        '{contrast: 6'h20, default: 0};
    logic sw_cmd;
    // Soft reset write, ignored while the pin holds the part in reset
    assign sw_cmd = i_psel && i_penable && i_pwrite && i_paddr == 12'h000
        && i_pwdata[7:0] == 8'he2 && i_hardware_reset_n;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_hw_disp;
        !i_hardware_reset_n |=> !o_core.display_on && !o_core.inverse
            && !o_core.seg_reverse;
    endproperty
    a_hw_disp: assert property (p_hw_disp)
        else $error("display settings not cleared by pin reset");
    property p_hw_power;
        !i_hardware_reset_n |=> o_core.power_ctrl == 3'h0
            && !o_core.power_save && !o_core.osc_on;
    endproperty
    a_hw_power: assert property (p_hw_power)
        else $error("power settings not cleared by pin reset");
    property p_hw_drive;
        !i_hardware_reset_n |=> !o_core.bias_1_7 && !o_core.nline_on
            && !o_core.all_on;
    endproperty
    a_hw_drive: assert property (p_hw_drive)
        else $error("drive settings not cleared by pin reset");
    property p_hw_soft;
        !i_hardware_reset_n ##1 !i_hardware_reset_n |=> o_soft == SOFT_DEF;
    endproperty
    a_hw_soft: assert property (p_hw_soft)
        else $error("shared settings not at defaults under pin reset");
    property p_disch_on;
        !i_hardware_reset_n |=> o_discharge_drive && o_discharge_boost;
    endproperty
    a_disch_on: assert property (p_disch_on)
        else $error("no discharge while pin reset low");
    property p_disch_off;
        i_hardware_reset_n |=> !o_discharge_drive && !o_discharge_boost;
    endproperty
    a_disch_off: assert property (p_disch_off)
        else $error("discharge still on after pin reset released");
    property p_hw_status;
        !i_hardware_reset_n |=> o_status == 8'hf0;
    endproperty
    a_hw_status: assert property (p_hw_status)
        else $error("status not busy and resetting under pin reset");
    property p_sw_keep;
        sw_cmd |=> o_soft == SOFT_DEF && $stable(o_core);
    endproperty
    a_sw_keep: assert property (p_sw_keep)
        else $error("soft reset result wrong");
    property p_sw_busy;
        sw_cmd |=> (o_status[7] && o_status[4]) [*8]
            ##1 (!o_status[7] && !o_status[4]);
    endproperty
    a_sw_busy: assert property (p_sw_busy)
        else $error("soft reset status timing wrong");
    c_sw: cover property (sw_cmd);
    c_hw: cover property ($rose(i_hardware_reset_n));
    c_ser: cover property (i_ser_valid [*8]);
endmodule
bind lcdrst_top lcdrst_top_properties i_props (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_hardware_reset_n(i_hardware_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_ser_valid(i_ser_valid),
    .o_core(o_core), .o_soft(o_soft), .o_status(o_status),
    .o_discharge_drive(o_discharge_drive),
    .o_discharge_boost(o_discharge_boost));

// File: lcdrst_host_model.sv
/*
 * Host side model: reset pin and serial command line.
 * Assumes the bench calls its tasks hierarchically.
 */
`timescale 1ns/1ps
module lcdrst_host_model (
    // Clock
    input wire logic i_clk,
    // Host pins
    output logic o_hardware_reset_n,
    output logic o_ser_valid,
    output logic o_ser_bit
);
    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    initial begin
        o_hardware_reset_n = 1'b0;
        o_ser_valid = 1'b0;
        o_ser_bit = 1'b0;
    end
    task automatic pulse_reset(input int n);
        @(posedge i_clk);
        o_hardware_reset_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_hardware_reset_n <= 1'b1;
    endtask
    // Sends the top n bits, most significant first
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_ser_valid <= 1'b1;
            o_ser_bit <= b[7-i];
        end
        @(posedge i_clk);
        o_ser_valid <= 1'b0;
        // Idle line is not held: show the inverse, never a stale bit
        o_ser_bit <= ~o_ser_bit;
    endtask
endmodule

// File: tb_lcdrst_top.sv
/*
 * Self-checking bench of the LCD driver reset block over APB.
 * Assumes the host model drives the reset pin and serial line.
 */
`timescale 1ns/1ps
`define CHECK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", nm, e, a); \
    end end
module tb_lcdrst_top;
    // ****************************************************************
    // Signals, design and host
    // ****************************************************************
    logic i_clk = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, e, hw_n, sv, sb;
    int miscompares = 0, n_checks = 0, cycles = 0;
    lcdrst_top i_lcdrst_top (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_hardware_reset_n(hw_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ser_valid(sv), .i_ser_bit(sb), .o_core(), .o_soft(),
        .o_discharge_drive(), .o_discharge_boost(), .o_status());
    lcdrst_host_model i_lcdrst_host_model (.i_clk(i_clk),
        .o_hardware_reset_n(hw_n), .o_ser_valid(sv), .o_ser_bit(sb));
    initial forever #5 i_clk = ~i_clk;
    // Whole run is about 150 cycles; the ceiling is generous
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        `CHECK("read data", x, q)
    endtask
    // Polls status until the resetting flag clears
    task automatic wait_init();
        q = 32'h0000_0010;
        for (int i = 0; i < 40 && q[4] !== 1'b0; i++)
            apb(1'b0, 12'h004, 32'h0000_0000);
    endtask
    task automatic defaults_all(input logic [31:0] ctrl, pwr);
        rd(12'h008, ctrl);
        rd(12'h00c, pwr);
        rd(12'h010, 32'h0000_0000);
        rd(12'h014, 32'h0000_0100);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        i_lcdrst_host_model.pulse_reset(3);
        wait_init();
        `CHECK("status", 32'h0000_0060, q)
        defaults_all(32'h0, 32'h0);
        $display("test power_up done");
        apb(1'b1, 12'h008, 32'h0000_007f);
        apb(1'b1, 12'h00c, 32'h0000_0007);
        apb(1'b1, 12'h010, 32'h003f_ffff);
        apb(1'b1, 12'h014, 32'h0000_7fff);
        rd(12'h014, 32'h0000_7fff);
        rd(12'h010, 32'h003f_ffff);
        apb(1'b1, 12'h000, 32'h0000_00e2);
        wait_init();
        `CHECK("status", 32'h0000_0000, q)
        defaults_all(32'h7f, 32'h7);
        $display("test soft_reset done");
        apb(1'b1, 12'h000, 32'h0000_00a9);
        rd(12'h00c, 32'h0000_000f);
        i_lcdrst_host_model.send_bits(8'ha5, 5);
        rd(12'h018, 32'h0000_0500);
        i_lcdrst_host_model.pulse_reset(2);
        wait_init();
        rd(12'h018, 32'h0000_0000);
        defaults_all(32'h0, 32'h0);
        $display("test pin_reset done");
        apb(1'b1, 12'h010, 32'h0000_0155);
        rd(12'h010, 32'h0000_0155);
        i_lcdrst_host_model.send_bits(8'he2, 8);
        wait_init();
        rd(12'h010, 32'h0000_0000);
        apb(1'b0, 12'h01c, 32'h0000_0000);
        `CHECK("slave error", 1'b1, e)
        `CHECK("unmapped data", 32'h0, q)
        $display("test serial_and_unmapped done");
        final_report();
    end
endmodule
